/* shared/drive_profile_pkg.sv */
/*
  Shared constants and types for the single-axis drive speed profiler:
  register offsets, mode and stop configuration bit positions, command
  codes, reset values, profile states and the register port carrier.
  Assumes a 32-bit register port with byte-address offsets.
*/
package drive_profile_pkg;

  // register byte offsets
  localparam logic [7:0] OFS_COMMAND     = 8'h00;
  localparam logic [7:0] OFS_DRIVE_MODE  = 8'h04;
  localparam logic [7:0] OFS_STOP_CFG    = 8'h08;
  localparam logic [7:0] OFS_INIT_SPEED  = 8'h0C;
  localparam logic [7:0] OFS_DRIVE_SPEED = 8'h10;
  localparam logic [7:0] OFS_ACCEL       = 8'h14;
  localparam logic [7:0] OFS_DECEL       = 8'h18;
  localparam logic [7:0] OFS_PULSE_COUNT = 8'h1C;
  localparam logic [7:0] OFS_ACC_OFFSET  = 8'h20;
  localparam logic [7:0] OFS_STATUS      = 8'h24;
  localparam logic [7:0] OFS_SPEED_NOW   = 8'h28;
  localparam logic [7:0] OFS_REMAINING   = 8'h2C;
  localparam logic [7:0] OFS_DECEL_POINT = 8'h30;

  // drive_mode_register bit positions
  localparam int MODE_MANUAL_DECEL   = 0; // manual_decel_point_select
  localparam int MODE_SEPARATE_DECEL = 1; // separate_decel_select
  localparam int MODE_SCURVE         = 2;
  localparam int MODE_TRIANGLE_PREV  = 5;
  localparam int MODE_W              = 6;

  // stop_input_config_register: input n uses enable bit 2n, level bit 2n+1
  localparam int HALT_INPUTS  = 3;
  localparam int STOP_CFG_W   = 6;

  // command codes
  localparam logic [7:0] CMD_PRESET_DECEL_POINT = 8'h07;
  localparam logic [7:0] CMD_FIXED_PLUS         = 8'h20;
  localparam logic [7:0] CMD_FIXED_MINUS        = 8'h21;
  localparam logic [7:0] CMD_CONT_PLUS          = 8'h22;
  localparam logic [7:0] CMD_CONT_MINUS         = 8'h23;
  localparam logic [7:0] CMD_DECEL_STOP         = 8'h26;
  localparam logic [7:0] CMD_SUDDEN_STOP        = 8'h27;

  // widths and reset values
  localparam int SPEED_W = 16;
  localparam int COUNT_W = 24;
  localparam int NCO_W   = 24;
  localparam int WSUM_W  = COUNT_W + SPEED_W;
  localparam logic [7:0] ACC_OFFSET_RESET = 8'h08;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ACCEL,
    ST_CONST,
    ST_DECEL
  } drive_state_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_t;

endpackage

/* hw/pulse_nco.sv */
/*
  Phase-accumulator pulse rate generator. Each clock adds the current
  speed word; a carry out marks one drive pulse, issued as a one-cycle
  registered strobe. Assumes the speed word comes from the same clock.
*/
`timescale 1ns/1ns
module pulse_nco
  import drive_profile_pkg::*;
(
  input  wire logic               sys_clk_i,  // system clock
  input  wire logic               resetn_i,   // synchronous reset, active low
  input  wire logic               run_i,      // accumulate while high
  input  wire logic [SPEED_W-1:0] speed_i,    // pulses per 2^NCO_W clocks
  output logic                    tick_o      // one-cycle pulse strobe
);

  logic [NCO_W-1:0] phase;
  logic [NCO_W:0]   next_phase;

  assign next_phase = {1'b0, phase} + {{(NCO_W + 1 - SPEED_W){1'b0}}, speed_i};

  // phase restarts at zero so the first pulse spacing is a full period
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i || !run_i) begin
      phase  <= '0;
      tick_o <= 1'b0;
    end else begin
      phase  <= next_phase[NCO_W-1:0];
      tick_o <= next_phase[NCO_W];
    end
  end

endmodule

/* hw/pulse_drive_speed_profile.sv */
/*
  Single-axis pulse drive speed profiler: register port, command decode,
  linear ramp generator, fixed and continuous drive state machine,
  automatic and manual deceleration point, triangle prevention and the
  three external halt inputs. Assumes halt inputs are asynchronous pins
  and the register port master runs on sys_clk_i.
*/
// Our own choices: the register addresses and the plain strobed port.
// How it works
// - continuous drive emits pulses until a stop command or enabled halt input.
// - drive speed may be rewritten while a ramped drive runs; rate ramps toward it.
// - decelerating stop ramps down first; sudden stop halts pulses at once.
// - three halt inputs, each with enable and level bits in config bits 5..0.
// - ramped continuous drive decelerates to stop on an active halt input.
// - constant-speed continuous drive halts immediately on an active halt input.
// - fixed and continuous commands both directions; profile follows the mode.
// - drive speed not above initial speed gives constant speed throughout.
// - linear acceleration climbs from initial speed at the programmed slope.
// - symmetric fixed drive decelerates when remaining pulses drop below accel pulses.
// - deceleration ends at initial speed; fixed drive ends after last pulse.
// - decel stop during acceleration or short move switches straight to decel.
// - triangle prevention holds speed once accel plus decel pulses pass half.
// - triangle prevention off at reset, on only while mode bit 5 is set.
// - non-symmetric decel start point is computed from count and both rates.
// - mode bit 1 selects the separate deceleration rate for ramping down.
// - mode bit 0 clear gives automatic deceleration point in fixed drive.
// - mode bit 0 set uses the decel point preset by command 07h.
// - acceleration counter offset resets to 8; positive decelerates earlier.
`timescale 1ns/1ns
module pulse_drive_speed_profile
  import drive_profile_pkg::*;
(
  input  wire logic                   sys_clk_i,     // 50 MHz system clock
  input  wire logic                   resetn_i,      // synchronous reset, active low
  input  wire reg_req_t               reg_req_i,     // register port request
  output logic [31:0]                 reg_rdata_o,   // read data, cycle after strobe
  input  wire logic [HALT_INPUTS-1:0] halt_pins_i,   // external_halt_inputs, async
  output logic                        plus_pulse_o,  // drive pulse, plus direction
  output logic                        minus_pulse_o, // drive pulse, minus direction
  output logic                        busy_o         // drive in progress
);

  drive_state_t        state;
  logic [MODE_W-1:0]     drive_mode;
  logic [STOP_CFG_W-1:0] stop_cfg;
  logic [SPEED_W-1:0]    init_speed;
  logic [SPEED_W-1:0]    drive_speed;
  logic [SPEED_W-1:0]    accel_rate;
  logic [SPEED_W-1:0]    decel_rate;
  logic [COUNT_W-1:0]    pulse_count;
  logic [7:0]            acc_offset;
  logic [COUNT_W-1:0]    decel_point;
  logic [SPEED_W-1:0]    speed;
  logic [COUNT_W-1:0]    remaining;
  logic [COUNT_W-1:0]    accel_pulses;
  logic [WSUM_W-1:0]     accel_weight;
  logic [SPEED_W-1:0]    ramp_frac;
  logic                  ramped;
  logic                  fixed_drive;
  logic                  minus_dir;
  logic                  tri_hold;
  logic                  pulse_tick;

  // command decode
  logic       cmd_wr;
  logic [7:0] cmd_code;
  logic       start_cmd;
  assign cmd_wr    = reg_req_i.wr && (reg_req_i.addr == OFS_COMMAND);
  assign cmd_code  = reg_req_i.wdata[7:0];
  assign start_cmd = cmd_wr && (state == ST_IDLE) &&
                     ((cmd_code == CMD_FIXED_PLUS) || (cmd_code == CMD_FIXED_MINUS) ||
                      (cmd_code == CMD_CONT_PLUS)  || (cmd_code == CMD_CONT_MINUS));

  // parameter and mode registers
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      drive_mode  <= '0;
      stop_cfg    <= '0;
      init_speed  <= '0;
      drive_speed <= '0;
      accel_rate  <= '0;
      decel_rate  <= '0;
      pulse_count <= '0;
      acc_offset  <= ACC_OFFSET_RESET;
    end else if (reg_req_i.wr) begin
      unique case (reg_req_i.addr)
        OFS_DRIVE_MODE:  drive_mode  <= reg_req_i.wdata[MODE_W-1:0];
        OFS_STOP_CFG:    stop_cfg    <= reg_req_i.wdata[STOP_CFG_W-1:0];
        OFS_INIT_SPEED:  init_speed  <= reg_req_i.wdata[SPEED_W-1:0];
        OFS_DRIVE_SPEED: drive_speed <= reg_req_i.wdata[SPEED_W-1:0];
        OFS_ACCEL:       accel_rate  <= reg_req_i.wdata[SPEED_W-1:0];
        OFS_DECEL:       decel_rate  <= reg_req_i.wdata[SPEED_W-1:0];
        OFS_PULSE_COUNT: pulse_count <= reg_req_i.wdata[COUNT_W-1:0];
        OFS_ACC_OFFSET:  acc_offset  <= reg_req_i.wdata[7:0];
        default:         ;
      endcase
    end
  end

  // manual decel point preset by command
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      decel_point <= '0;
    end else if (cmd_wr && (cmd_code == CMD_PRESET_DECEL_POINT)) begin
      decel_point <= reg_req_i.wdata[COUNT_W+7:8];
    end
  end

  // halt inputs: two-flop synchronisers, then enable and level per input
  logic [HALT_INPUTS-1:0] halt_meta;
  logic [HALT_INPUTS-1:0] halt_sync;
  logic [HALT_INPUTS-1:0] halt_active;
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      halt_meta <= '0;
      halt_sync <= '0;
    end else begin
      halt_meta <= halt_pins_i;
      halt_sync <= halt_meta;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < HALT_INPUTS; gi++) begin : g_halt
      // level bit set means active high
      assign halt_active[gi] = stop_cfg[2*gi] && (halt_sync[gi] == stop_cfg[2*gi+1]);
    end
  endgenerate

  logic halt_hit;
  assign halt_hit = (|halt_active) && !fixed_drive && (state != ST_IDLE) && (state != ST_DECEL);

  // ramp direction and rate
  logic                 ramp_up;
  logic                 ramp_down;
  logic [SPEED_W-1:0]   down_rate;
  logic [SPEED_W-1:0]   ramp_rate;
  logic [SPEED_W:0]     ramp_sum;
  assign down_rate = drive_mode[MODE_SEPARATE_DECEL] ? decel_rate : accel_rate;
  // constant slope up from initial speed
  assign ramp_up   = (state == ST_ACCEL) ||
                     ((state == ST_CONST) && ramped && !tri_hold && (speed < drive_speed));
  assign ramp_down = ((state == ST_DECEL) && (speed > init_speed)) ||
                     ((state == ST_CONST) && ramped && (speed > drive_speed));
  assign ramp_rate = ramp_up ? accel_rate : down_rate;
  assign ramp_sum  = {1'b0, ramp_frac} + {1'b0, ramp_rate};

  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i || start_cmd || !(ramp_up || ramp_down)) begin
      ramp_frac <= '0;
    end else begin
      ramp_frac <= ramp_sum[SPEED_W-1:0];
    end
  end

  // current speed; a carry of the ramp accumulator moves it one step
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      speed <= '0;
    end else if (start_cmd) begin
      // no ramp when drive speed is not above initial
      speed <= (drive_speed > init_speed) ? init_speed : drive_speed;
    end else if (ramp_sum[SPEED_W] && ramp_up && (speed < drive_speed)) begin
      speed <= speed + 1'b1;
    end else if (ramp_sum[SPEED_W] && ramp_down) begin
      speed <= speed - 1'b1;
    end
  end

  pulse_nco u_nco (
    .sys_clk_i (sys_clk_i),
    .resetn_i  (resetn_i),
    .run_i     (state != ST_IDLE),
    .speed_i   (speed),
    .tick_o    (pulse_tick)
  );

  // drive attributes latched at start
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      ramped      <= 1'b0;
      fixed_drive <= 1'b0;
      minus_dir   <= 1'b0;
    end else if (start_cmd) begin
      ramped      <= drive_speed > init_speed;
      fixed_drive <= (cmd_code == CMD_FIXED_PLUS) || (cmd_code == CMD_FIXED_MINUS);
      minus_dir   <= (cmd_code == CMD_FIXED_MINUS) || (cmd_code == CMD_CONT_MINUS);
    end
  end

  // pulse bookkeeping: remaining count, accel pulses and weighted sum
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      remaining    <= '0;
      accel_pulses <= '0;
      accel_weight <= '0;
    end else if (start_cmd) begin
      remaining    <= pulse_count;
      accel_pulses <= '0;
      accel_weight <= '0;
    end else if (pulse_tick) begin
      if (fixed_drive && (remaining != '0)) begin
        remaining <= remaining - 1'b1;
      end
      if (state == ST_ACCEL) begin
        accel_pulses <= accel_pulses + 1'b1;
        accel_weight <= accel_weight + {{COUNT_W{1'b0}}, accel_rate};
      end
    end
  end

  // deceleration point: decel pulses scale as accel pulses times accel/decel,
  // so remaining * decel is held against the sum of accel per accel pulse
  logic signed [COUNT_W+1:0] rem_adj;
  logic [WSUM_W-1:0]         rem_weight;
  logic                      auto_point;
  logic                      manual_point;
  logic                      decel_due;
  logic                      triangle_due;
  assign rem_adj = $signed({2'b00, remaining}) -
                   $signed({{(COUNT_W-6){acc_offset[7]}}, acc_offset});
  // computed start point from count and both rates
  assign rem_weight = rem_adj[COUNT_W-1:0] * down_rate;
  // symmetric case reduces to remaining below accel pulses
  assign auto_point   = (rem_adj <= 0) || (rem_weight <= accel_weight);
  assign manual_point = remaining <= decel_point;
  // automatic point when bit 0 clear
  assign decel_due = fixed_drive && ramped && (state != ST_DECEL) &&
                     (drive_mode[MODE_MANUAL_DECEL] ? manual_point : auto_point);
  // accel plus decel pulses beyond half of total
  assign triangle_due = drive_mode[MODE_TRIANGLE_PREV] && fixed_drive &&
                        ({accel_pulses, 2'b00} > {2'b00, pulse_count});

  logic fixed_done;
  assign fixed_done = fixed_drive && pulse_tick && (remaining <= 1);

  // profile state machine
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      state    <= ST_IDLE;
      tri_hold <= 1'b0;
    end else if (start_cmd) begin
      state    <= (drive_speed > init_speed) ? ST_ACCEL : ST_CONST;
      tri_hold <= 1'b0;
    end else if (state != ST_IDLE) begin
      if (cmd_wr && (cmd_code == CMD_SUDDEN_STOP)) begin
        state <= ST_IDLE;
      end else if (fixed_done || (fixed_drive && (remaining == '0))) begin
        state <= ST_IDLE;
      end else if (halt_hit && !ramped) begin
        state <= ST_IDLE;
      end else if (halt_hit || (cmd_wr && (cmd_code == CMD_DECEL_STOP)) || decel_due) begin
        state <= ST_DECEL;
      end else begin
        unique case (state)
          ST_ACCEL: begin
            if (triangle_due) begin
              state    <= ST_CONST;
              tri_hold <= 1'b1;
            end else if (speed >= drive_speed) begin
              state <= ST_CONST;
            end
          end
          ST_DECEL: begin
            // continuous drive's ramped stop ends at initial speed on a pulse; fixed drive ends on its count
            if (!fixed_drive && pulse_tick && (speed <= init_speed)) begin
              state <= ST_IDLE;
            end
          end
          // continuous drive runs until stop command or halt input
          ST_CONST: ;
          ST_IDLE:  ;
        endcase
      end
    end
  end

  // drive pulse outputs follow the rate generator while running
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      plus_pulse_o  <= 1'b0;
      minus_pulse_o <= 1'b0;
      busy_o        <= 1'b0;
    end else begin
      plus_pulse_o  <= pulse_tick && (state != ST_IDLE) && !minus_dir;
      minus_pulse_o <= pulse_tick && (state != ST_IDLE) && minus_dir;
      busy_o        <= (state != ST_IDLE) || start_cmd;
    end
  end

  // read mux; unmapped offsets read as zero
  logic [31:0] next_rdata;
  always_comb begin
    next_rdata = '0;
    unique case (reg_req_i.addr)
      OFS_DRIVE_MODE:  next_rdata[MODE_W-1:0]     = drive_mode;
      OFS_STOP_CFG:    next_rdata[STOP_CFG_W-1:0] = stop_cfg;
      OFS_INIT_SPEED:  next_rdata[SPEED_W-1:0]    = init_speed;
      OFS_DRIVE_SPEED: next_rdata[SPEED_W-1:0]    = drive_speed;
      OFS_ACCEL:       next_rdata[SPEED_W-1:0]    = accel_rate;
      OFS_DECEL:       next_rdata[SPEED_W-1:0]    = decel_rate;
      OFS_PULSE_COUNT: next_rdata[COUNT_W-1:0]    = pulse_count;
      OFS_ACC_OFFSET:  next_rdata[7:0]            = acc_offset;
      OFS_STATUS:      next_rdata[7:0]            = {halt_sync, tri_hold, minus_dir,
                                                     state != ST_IDLE, state};
      OFS_SPEED_NOW:   next_rdata[SPEED_W-1:0]    = speed;
      OFS_REMAINING:   next_rdata[COUNT_W-1:0]    = remaining;
      OFS_DECEL_POINT: next_rdata[COUNT_W-1:0]    = decel_point;
      default:         next_rdata = '0;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      reg_rdata_o <= '0;
    end else if (reg_req_i.rd) begin
      reg_rdata_o <= next_rdata;
    end else begin
      reg_rdata_o <= '0;
    end
  end

endmodule

/* dv/pulse_drive_speed_profile_props.sv */
/*
  Port checker for the drive speed profiler.
  Assumes it is bound to the profiler top and sees its ports only.
*/
`timescale 1ns/1ns
module pulse_drive_speed_profile_props
  import drive_profile_pkg::*;
(
  input wire logic                   sys_clk_i,     // system clock
  input wire logic                   resetn_i,      // sync reset, active low
  input wire reg_req_t               reg_req_i,     // register request
  input wire logic [31:0]            reg_rdata_o,   // read data
  input wire logic [HALT_INPUTS-1:0] halt_pins_i,   // halt pins, unused here
  input wire logic                   plus_pulse_o,  // plus drive pulse
  input wire logic                   minus_pulse_o, // minus drive pulse
  input wire logic                   busy_o         // drive in progress
);
  logic dir_minus;
  logic cmd_wr;
  logic pulse;

  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);

  // command decode shared by several properties
  assign cmd_wr = reg_req_i.wr && (reg_req_i.addr == OFS_COMMAND);
  assign pulse  = plus_pulse_o || minus_pulse_o;

  // direction latched only on an accepted start, starts while busy are ignored
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      dir_minus <= 1'b0;
    end else if (cmd_wr && !busy_o && reg_req_i.wdata[7:2] == 6'h08) begin
      dir_minus <= reg_req_i.wdata[0];
    end
  end

  property p_single_strobe;
    pulse |=> !pulse [*8];
  endproperty
  a_single_strobe: assert property (p_single_strobe) else $error("pulse too wide");

  property p_dir_plus;
    plus_pulse_o |-> !dir_minus && !minus_pulse_o;
  endproperty
  a_dir_plus: assert property (p_dir_plus) else $error("plus pulse in minus drive");

  property p_dir_minus;
    minus_pulse_o |-> dir_minus;
  endproperty
  a_dir_minus: assert property (p_dir_minus) else $error("minus pulse in plus drive");

  property p_start_busy;
    cmd_wr && !busy_o && reg_req_i.wdata[7:1] == 7'h11 |=> busy_o;
  endproperty
  a_start_busy: assert property (p_start_busy) else $error("start not taken");

  property p_idle_quiet;
    !busy_o ##1 !busy_o |-> !pulse;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("pulse while idle");

  property p_sudden;
    busy_o && cmd_wr && reg_req_i.wdata[7:0] == CMD_SUDDEN_STOP |-> ##[1:3] !busy_o;
  endproperty
  a_sudden: assert property (p_sudden) else $error("sudden stop too slow");

  property p_rdata_zero;
    !reg_req_i.rd |=> reg_rdata_o == 32'h0;
  endproperty
  a_rdata_zero: assert property (p_rdata_zero) else $error("read data outside slot");

  property p_reset;
    disable iff (1'b0) !resetn_i |=> !busy_o && !pulse && reg_rdata_o == 32'h0;
  endproperty
  a_reset: assert property (p_reset) else $error("outputs active in reset");

  c_minus: cover property (minus_pulse_o);
  c_decel: cover property (busy_o && cmd_wr && reg_req_i.wdata[7:0] == CMD_DECEL_STOP);
  c_end: cover property (busy_o ##1 !busy_o);
endmodule

bind pulse_drive_speed_profile pulse_drive_speed_profile_props u_props (
  .sys_clk_i     (sys_clk_i),
  .resetn_i      (resetn_i),
  .reg_req_i     (reg_req_i),
  .reg_rdata_o   (reg_rdata_o),
  .halt_pins_i   (halt_pins_i),
  .plus_pulse_o  (plus_pulse_o),
  .minus_pulse_o (minus_pulse_o),
  .busy_o        (busy_o)
);

/* dv/drive_host_model.sv */
/*
  Host processor model: register writes, reads and drive setup.
  Assumes the profiler's one-cycle register port on the same clock.
*/
`timescale 1ns/1ns
module drive_host_model
  import drive_profile_pkg::*;
(
  input  wire logic        sys_clk_i, // system clock
  input  wire logic [31:0] rdata_i,   // read data from the profiler
  output reg_req_t         req_o      // register request
);
  initial req_o = '0;

  // one-cycle write strobe, dropped on the next edge
  task automatic wr_reg(input logic [7:0] addr, input logic [31:0] data);
    @(posedge sys_clk_i);
    req_o <= {addr, data, 1'b1, 1'b0};
    @(posedge sys_clk_i);
    req_o.wr <= 1'b0;
  endtask

  // data is taken in the single cycle after the strobe
  task automatic rd_reg(input logic [7:0] addr, output logic [31:0] data);
    @(posedge sys_clk_i);
    req_o <= {addr, 32'h0, 1'b0, 1'b1};
    @(posedge sys_clk_i);
    req_o.rd <= 1'b0;
    @(posedge sys_clk_i);
    data = rdata_i;
  endtask

  // parameters first
  // decel equal to accel keeps the decel lower bound without any arithmetic
  task automatic setup(input logic [15:0] init, input logic [15:0] drv,
                       input logic [15:0] rate, input logic [23:0] cnt);
    wr_reg(OFS_INIT_SPEED, {16'h0, init});
    wr_reg(OFS_DRIVE_SPEED, {16'h0, drv});
    wr_reg(OFS_ACCEL, {16'h0, rate});
    wr_reg(OFS_DECEL, {16'h0, rate});
    wr_reg(OFS_PULSE_COUNT, {8'h0, cnt});
  endtask
endmodule

/* dv/pulse_drive_speed_profile_tb.sv */
/*
  Self-checking bench for the drive speed profiler.
  Assumes the host model for register traffic and drives the halt pins itself.
*/
`timescale 1ns/1ns
module pulse_drive_speed_profile_tb
  import drive_profile_pkg::*;
;
  logic        sys_clk;
  logic        resetn;
  reg_req_t    reg_req;
  logic [31:0] reg_rdata;
  logic [2:0]  external_halt_inputs;
  logic        plus_pulse;
  logic        minus_pulse;
  logic        busy;
  logic [31:0] rdv;
  int          fail_count;
  int          checks;
  int          plus_n = 0;
  int          minus_n = 0;
  int          exp_p;

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  // pulse tallies, compared against expected totals
  always @(posedge sys_clk) begin
    plus_n += int'(plus_pulse);
    minus_n += int'(minus_pulse);
  end

  drive_host_model host (
    .sys_clk_i (sys_clk),
    .rdata_i   (reg_rdata),
    .req_o     (reg_req)
  );

  pulse_drive_speed_profile dut (
    .sys_clk_i     (sys_clk),
    .resetn_i      (resetn),
    .reg_req_i     (reg_req),
    .reg_rdata_o   (reg_rdata),
    .halt_pins_i   (external_halt_inputs),
    .plus_pulse_o  (plus_pulse),
    .minus_pulse_o (minus_pulse),
    .busy_o        (busy)
  );

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // bounded wait for the drive to end; a hang closes the run
  task automatic wait_idle(input int bound);
    for (int i = 0; i < bound; i++) begin
      @(posedge sys_clk);
      if (busy === 1'b0) return;
    end
    fail_count++;
    $display("CHECK FAILED t=%0t drive never ended", $time);
    summarize();
  endtask

  task automatic cmd(input logic [7:0] code);
    host.wr_reg(OFS_COMMAND, {24'h0, code});
  endtask

  initial begin
    resetn = 1'b0;
    external_halt_inputs = 3'h0;
    fail_count = 0;
    checks = 0;
    cycles(5);
    resetn <= 1'b1;
    // defaults, an unmapped place and the triangle mode bit
    host.rd_reg(OFS_ACC_OFFSET, rdv);
    check(rdv, 32'h8);
    host.rd_reg(OFS_DRIVE_MODE, rdv);
    check(rdv, 32'h0);
    host.rd_reg(8'h3C, rdv);
    check(rdv, 32'h0);
    host.wr_reg(OFS_DRIVE_MODE, 32'h20);
    host.rd_reg(OFS_DRIVE_MODE, rdv);
    check(rdv, 32'h20);
    host.wr_reg(OFS_DRIVE_MODE, 32'h0);
    $display("registers done");
    // constant speed fixed moves, plus then minus
    for (int d = 0; d < 2; d++) begin
      host.setup(16'hFFFF, 16'hFFFF, 16'h0, 24'(3 - d));
      cmd(CMD_FIXED_PLUS | 8'(d));
      host.rd_reg(OFS_SPEED_NOW, rdv);
      check(rdv, 32'hFFFF);
      wait_idle(3000);
      cycles(2);
      check(plus_n, 3);
      check(minus_n, 2 * d);
    end
    $display("constant fixed done");
    // ramped fixed move too short to reach drive speed
    host.setup(16'h4000, 16'hC000, 16'hFFFF, 24'h28); // high initial speed
    cmd(CMD_FIXED_PLUS);
    cycles(3000);
    host.rd_reg(OFS_SPEED_NOW, rdv);
    check({31'h0, rdv > 32'h4000 && rdv < 32'hC000}, 32'h1);
    wait_idle(60000);
    cycles(2);
    check(plus_n, 43);
    $display("ramped fixed done");
    // constant continuous drive cut by a sudden stop
    host.setup(16'hFFFF, 16'hFFFF, 16'h0, 24'h0);
    cmd(CMD_CONT_PLUS);
    cycles(2000);
    check(busy, 1'b1);
    cmd(CMD_SUDDEN_STOP);
    cycles(3);
    check(busy, 1'b0);
    exp_p = plus_n;
    cycles(600);
    check(plus_n, exp_p);
    $display("sudden stop done");
    // z-phase on top input, active high; others disabled
    host.wr_reg(OFS_STOP_CFG, 32'h30);
    for (int r = 0; r < 2; r++) begin
      host.setup(r ? 16'h4000 : 16'hFFFF, r ? 16'h8000 : 16'hFFFF, 16'hFFFF, 24'h0);
      cmd(CMD_CONT_PLUS);
      cycles(3000);
      external_halt_inputs <= 3'h3;
      cycles(10);
      check(busy, 1'b1);
      external_halt_inputs <= 3'h4;
      cycles(6);
      check(busy, r ? 1'b1 : 1'b0);
      wait_idle(30000);
      external_halt_inputs <= 3'h0;
    end
    $display("halt inputs done");
    // minus continuous drive, speed rewritten, then ramped stop
    exp_p = minus_n;
    host.setup(16'h4000, 16'h8000, 16'hFFFF, 24'h0);
    cmd(CMD_CONT_MINUS);
    cycles(8000);
    host.wr_reg(OFS_DRIVE_SPEED, 32'h5000);
    cycles(20000);
    host.rd_reg(OFS_SPEED_NOW, rdv);
    check(rdv, 32'h5000);
    cmd(CMD_DECEL_STOP);
    cycles(3);
    check(busy, 1'b1);
    wait_idle(20000);
    check({31'h0, minus_n > exp_p}, 32'h1);
    $display("decel stop done");
    // manual point: ramps up, then down only with two pulses left
    host.wr_reg(OFS_DRIVE_MODE, 32'h1);
    host.setup(16'h4000, 16'hC000, 16'hFFFF, 24'h8);
    host.wr_reg(OFS_COMMAND, {24'h2, CMD_PRESET_DECEL_POINT});
    host.rd_reg(OFS_DECEL_POINT, rdv);
    check(rdv, 32'h2);
    exp_p = plus_n + 8;
    cmd(CMD_FIXED_PLUS);
    wait_idle(20000);
    cycles(2);
    check(plus_n, exp_p);
    // an automatic point would never leave the initial speed here
    host.rd_reg(OFS_SPEED_NOW, rdv);
    check({31'h0, rdv > 32'h4000}, 32'h1);
    $display("manual decel done");
    summarize();
  end
endmodule
